/* msm_pkg.sv */
// constants and carrier types for the manchester sensor messaging block
`default_nettype none
package msm_pkg;
  localparam int CLK_PERIOD_PS = 5000;
  // shortest half bit accepted; shorter low pulses are taken as noise
  localparam int MIN_HALF_NS = 50;
  localparam int MIN_HALF_CYC =
    (MIN_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_LEN = 16;
  localparam int WRITE_LEN = 32;
  localparam int RESP_LEN = 27;
  // status and data bits only: sync pair and the crc itself stay out
  localparam int RESP_CRC_BITS = 22;
  localparam int RW_POS = 2;
  localparam logic [5:0] ACCESS_ADDR = 6'h3F;
  localparam logic [15:0] ACCESS_DATA = 16'h62D2;
  localparam logic [2:0] CRC_INIT = 3'h7;
  localparam logic [1:0] SYNC_PAIR = 2'h0;

  typedef struct packed {
    logic [1:0] dieId;
    logic broadcastFlag;
    logic abortErrorFlag;
    logic overrunFlag;
    logic checksumFailFlag;
  } msm_status_t;

  typedef struct packed {
    logic [3:0] target;
    logic [5:0] addr;
    logic [15:0] data;
  } msm_wr_t;
endpackage
`default_nettype wire

/* msm_link.sv */
// manchester command receiver and read response transmitter
`timescale 1ns/1ps
`default_nettype none
module msm_link #(
  parameter int CNTW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supplyLevel,
  input wire logic [1:0] dieSel,
  input wire logic spiModeActive,
  input wire logic [15:0] rdWord,
  input wire logic pwmIn,
  output logic pwmOut,
  output logic pwmOe,
  output logic manchesterMode,
  output logic txBusy,
  output logic rdStrobe,
  output logic [5:0] rdAddr,
  output logic wrStrobe,
  output msm_pkg::msm_wr_t wrCmd,
  output logic abortErrorFlag,
  output logic overrunFlag,
  output logic checksumFailFlag
);
  typedef enum logic [1:0] {RX_IDLE, RX_MEAS, RX_BITS} msm_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} msm_tx_t;

  function automatic logic [2:0] crcStep(input logic [2:0] c, input logic d);
    crcStep = {c[1], c[2] ^ d ^ c[0], c[2] ^ d};
  endfunction

  function automatic logic [2:0] crcOf(
    input logic [msm_pkg::RESP_CRC_BITS-1:0] v);
    logic [2:0] c;
    c = msm_pkg::CRC_INIT;
    for (int i = msm_pkg::RESP_CRC_BITS - 1; i >= 0; i--) begin
      c = crcStep(c, v[i]);
    end
    crcOf = c;
  endfunction

  msm_rx_t rxState_r;
  msm_tx_t txState_r;
  logic lineD_r;
  logic [1:0] dieId_r;
  logic [CNTW-1:0] rxHalf_r;
  logic [CNTW+1:0] rxTimer_r;
  logic [5:0] bitCnt_r;
  logic rw_r;
  logic [31:0] sh_r;
  logic [2:0] crc_r;
  logic rxDone_r;
  logic rxAbort;
  logic [CNTW-1:0] txHalf_r;
  logic [CNTW-1:0] txCnt_r;
  logic txPhase_r;
  logic [4:0] txIdx_r;
  localparam int RESP_BITS = msm_pkg::RESP_LEN;
  logic [RESP_BITS-1:0] txSh_r;
  logic broadcastFlag_r;

  // receiver edge decode
  logic rise;
  logic fall;
  logic edgeSeen;
  logic [CNTW+1:0] winLo;
  logic [CNTW+1:0] winMid;
  logic [CNTW+1:0] winHi;
  logic dataEdge;
  logic [5:0] frameLen;
  logic [5:0] cntNew;

  assign rise = supplyLevel & ~lineD_r;
  assign fall = ~supplyLevel & lineD_r;
  assign edgeSeen = rise | fall;
  assign winLo = {3'h0, rxHalf_r[CNTW-1:1]};
  assign winMid = {2'h0, rxHalf_r} + winLo;
  assign winHi = winMid + {2'h0, rxHalf_r};
  assign dataEdge = edgeSeen && rxTimer_r >= winMid;
  assign cntNew = bitCnt_r + 6'h01;
  always_comb begin
    if (bitCnt_r == 6'(msm_pkg::RW_POS)) begin
      frameLen = fall ? 6'(msm_pkg::READ_LEN) : 6'(msm_pkg::WRITE_LEN);
    end else begin
      frameLen = rw_r ? 6'(msm_pkg::READ_LEN) : 6'(msm_pkg::WRITE_LEN);
    end
  end
  // too-early edge, missing edge, or a one in the second sync slot
  assign rxAbort = rxState_r == RX_BITS && ((edgeSeen && rxTimer_r < winLo)
    || rxTimer_r > winHi || (dataEdge && bitCnt_r == 6'h01 && fall));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lineD_r <= 1'b1;
      dieId_r <= 2'h0;
    end else begin
      lineD_r <= supplyLevel;
      dieId_r <= dieSel;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_r <= RX_IDLE;
      rxHalf_r <= '0;
      rxTimer_r <= '0;
      bitCnt_r <= 6'h00;
      rw_r <= 1'b0;
      sh_r <= 32'h0000_0000;
      crc_r <= msm_pkg::CRC_INIT;
      rxDone_r <= 1'b0;
    end else begin
      rxDone_r <= 1'b0;
      case (rxState_r)
        RX_IDLE: begin
          rxTimer_r <= '0;
          if (fall) begin
            rxState_r <= RX_MEAS;
          end
        end
        RX_MEAS: begin
          // low half of the first sync zero gives this frame's rate
          rxTimer_r <= rxTimer_r + 1'b1;
          if (rise) begin
            // timer starts one cycle after the fall, so add that cycle
            if (rxTimer_r < (CNTW+2)'(msm_pkg::MIN_HALF_CYC - 1)) begin
              rxState_r <= RX_IDLE;
            end else begin
              rxHalf_r <= rxTimer_r[CNTW-1:0] + 1'b1;
              rxTimer_r <= '0;
              bitCnt_r <= 6'h01;
              sh_r <= 32'h0000_0000;
              crc_r <= msm_pkg::CRC_INIT;
              rxState_r <= RX_BITS;
            end
          end else if (rxTimer_r[CNTW]) begin
            rxState_r <= RX_IDLE;
          end
        end
        RX_BITS: begin
          rxTimer_r <= rxTimer_r + 1'b1;
          if (rxAbort) begin
            rxState_r <= RX_IDLE;
          end else if (dataEdge) begin
            // falling mid-bit edge carries a one
            sh_r <= {sh_r[30:0], fall};
            if (bitCnt_r >= 6'(msm_pkg::RW_POS) && cntNew <= frameLen - 6'h03)
            begin
              crc_r <= crcStep(crc_r, fall);
            end
            if (bitCnt_r == 6'(msm_pkg::RW_POS)) begin
              rw_r <= fall;
            end
            bitCnt_r <= cntNew;
            rxTimer_r <= '0;
            if (cntNew == frameLen) begin
              rxDone_r <= 1'b1;
              rxState_r <= RX_IDLE;
            end
          end
        end
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end

  // frame fields, valid while rxDone_r is high
  logic isRead;
  logic [3:0] tid;
  logic [5:0] addr;
  logic [15:0] wdata;
  logic crcOk;
  logic selected;
  logic isModeCode;
  logic txLoad;
  logic readAccept;
  msm_pkg::msm_status_t statNxt;
  logic [15:0] txWord;

  assign isRead = rw_r;
  assign tid = isRead ? sh_r[12:9] : sh_r[28:25];
  assign addr = isRead ? sh_r[8:3] : sh_r[24:19];
  assign wdata = sh_r[18:3];
  assign crcOk = sh_r[2:0] == crc_r;
  assign selected = tid == 4'h0 || tid[dieId_r];
  assign isModeCode = !isRead && addr == msm_pkg::ACCESS_ADDR;
  // a complete read or write during a response is dropped as an overrun; a mode code still applies
  assign readAccept = rxDone_r && crcOk && isRead && manchesterMode
    && selected && txState_r == TX_IDLE;
  assign txLoad = txState_r == TX_WAIT && txCnt_r == txHalf_r - 1'b1;
  // odd address: only the odd byte, high byte forced to zero
  assign txWord = rdAddr[0] ? {8'h00, rdWord[7:0]} : rdWord;
  always_comb begin
    statNxt.broadcastFlag = broadcastFlag_r;
    statNxt.dieId = broadcastFlag_r ? 2'h0 : dieId_r;
    statNxt.abortErrorFlag = abortErrorFlag;
    statNxt.overrunFlag = overrunFlag;
    statNxt.checksumFailFlag = checksumFailFlag;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      manchesterMode <= 1'b0;
    end else if (rxDone_r && crcOk && isModeCode) begin
      manchesterMode <= wdata == msm_pkg::ACCESS_DATA;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrStrobe <= 1'b0;
      wrCmd <= '0;
      rdStrobe <= 1'b0;
      rdAddr <= 6'h00;
      broadcastFlag_r <= 1'b0;
    end else begin
      wrStrobe <= rxDone_r && crcOk && !isRead && !isModeCode && manchesterMode
        && selected && txState_r == TX_IDLE;
      rdStrobe <= readAccept;
      if (rxDone_r && !isRead) begin
        wrCmd <= '{target: tid, addr: addr, data: wdata};
      end
      if (readAccept) begin
        rdAddr <= addr;
        broadcastFlag_r <= tid == 4'h0 || spiModeActive;
      end
    end
  end

  // sticky errors: a new event in the clearing cycle survives
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      abortErrorFlag <= 1'b0;
      overrunFlag <= 1'b0;
      checksumFailFlag <= 1'b0;
    end else begin
      abortErrorFlag <= rxAbort || (abortErrorFlag && !txLoad);
      overrunFlag <= (rxDone_r && txState_r != TX_IDLE)
        || (overrunFlag && !txLoad);
      checksumFailFlag <= (rxDone_r && !crcOk)
        || (checksumFailFlag && !txLoad);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_r <= TX_IDLE;
      txHalf_r <= '0;
      txCnt_r <= '0;
      txPhase_r <= 1'b0;
      txIdx_r <= 5'h00;
      txSh_r <= '0;
      txBusy <= 1'b0;
      pwmOe <= 1'b0;
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= 1'b0;
      case (txState_r)
        TX_IDLE: begin
          pwmOe <= 1'b0;
          if (readAccept) begin
            // waits out the second half of the last crc bit
            txHalf_r <= rxHalf_r;
            txCnt_r <= '0;
            txBusy <= 1'b1;
            txState_r <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          txCnt_r <= txCnt_r + 1'b1;
          if (txLoad) begin
            txSh_r <= {msm_pkg::SYNC_PAIR, statNxt, txWord,
              crcOf({statNxt, txWord})};
            txCnt_r <= '0;
            txPhase_r <= 1'b0;
            txIdx_r <= 5'h00;
            pwmOe <= 1'b1;
            txState_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          txCnt_r <= txCnt_r + 1'b1;
          if (txCnt_r == txHalf_r - 1'b1) begin
            txCnt_r <= '0;
            txPhase_r <= ~txPhase_r;
            if (!txPhase_r) begin
              pwmOe <= txSh_r[RESP_BITS-1];
            end else if (txIdx_r == 5'(RESP_BITS - 1)) begin
              pwmOe <= 1'b0;
              txBusy <= 1'b0;
              txState_r <= TX_IDLE;
            end else begin
              txIdx_r <= txIdx_r + 5'h01;
              txSh_r <= {txSh_r[RESP_BITS-2:0], 1'b0};
              pwmOe <= ~txSh_r[RESP_BITS-2];
            end
          end
        end
        default: txState_r <= TX_IDLE;
      endcase
    end
  end

  chk_od_low_only: assert property (@(posedge clk) disable iff (!rst_n)
    pwmOut == 1'b0) else $error("response pin driven high");
  chk_resp_needs_mode: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(txBusy) |-> manchesterMode) else $error("reply outside mode");
  chk_read_starts_tx: assert property (@(posedge clk) disable iff (!rst_n)
    readAccept |=> txBusy && rdStrobe ##1 !rdStrobe)
    else $error("read not answered");
  chk_bcast_value: assert property (@(posedge clk) disable iff (!rst_n)
    readAccept |=> broadcastFlag_r == ($past(tid) == 4'h0 || $past(spiModeActive)))
    else $error("broadcast flag wrong");
  chk_bcast_id: assert property (@(posedge clk) disable iff (!rst_n)
    txLoad |=> txSh_r[24:23] == (broadcastFlag_r ? 2'h0 : dieId_r))
    else $error("response id wrong");
  chk_crc_flag: assert property (@(posedge clk) disable iff (!rst_n)
    rxDone_r && !crcOk |=> checksumFailFlag && !rdStrobe && !wrStrobe)
    else $error("crc failure not recorded");
  chk_overrun_flag: assert property (@(posedge clk) disable iff (!rst_n)
    rxDone_r && txBusy && txState_r != TX_IDLE |=> overrunFlag)
    else $error("overrun not recorded");
  chk_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
    txLoad && !rxAbort |=> !abortErrorFlag)
    else $error("abort flag not cleared");
  chk_odd_zero: assert property (@(posedge clk) disable iff (!rst_n)
    txLoad && rdAddr[0] |=> txSh_r[18:11] == 8'h00)
    else $error("odd read high byte not zero");
  chk_mode_codes: assert property (@(posedge clk) disable iff (!rst_n)
    rxDone_r && crcOk && isModeCode |=>
    manchesterMode == ($past(wdata) == msm_pkg::ACCESS_DATA))
    else $error("mode code not applied");
  chk_resp_sync: assert property (@(posedge clk) disable iff (!rst_n)
    txLoad |=> pwmOe && txSh_r[26:25] == 2'h0)
    else $error("response not opening with sync zero");

  cov_access: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(manchesterMode));
  cov_response: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(txBusy));
  cov_overrun: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(overrunFlag));
  cov_crc_fail: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(checksumFailFlag));
endmodule // msm_link
`default_nettype wire

/* msm_ctrl.sv */
// behavioural programming controller: supply modulation out, response in
`timescale 1ns/1ps
`default_nettype none
module msm_ctrl (
  input wire logic clk,
  input wire logic pinLevel,
  output logic supplyLevel
);
  int half = 12;
  logic [26:0] resp;
  initial supplyLevel = 1'h1;

  // first half carries the bit value, so each mid edge is the bit
  task automatic sendFrame(input logic [31:0] f, input int n);
    for (int i = n - 1; i >= 0; i--) begin // msb first
      supplyLevel = f[i];
      repeat (half) @(negedge clk);
      supplyLevel = ~f[i];
      repeat (half) @(negedge clk);
    end
    supplyLevel = 1'h1;
  endtask

  // samples each bit in its first half at the rate this side chose
  task automatic getResp(output logic ok);
    int t;
    ok = 1'h0;
    for (t = 0; t < 80 * half && pinLevel !== 1'h0; t++) @(negedge clk);
    if (pinLevel !== 1'h0) return;
    repeat (half / 2) @(negedge clk);
    for (int i = 26; i >= 0; i--) begin
      resp[i] = pinLevel;
      repeat (2 * half) @(negedge clk);
    end
    ok = 1'h1;
  endtask
endmodule // msm_ctrl
`default_nettype wire

/* manchester_sensor_messaging_bench.sv */
// self-checking bench for the manchester messaging link
`timescale 1ns/1ps
`default_nettype none
module manchester_sensor_messaging_bench;
  logic clk = 1'h0;
  logic rst_n;
  logic [1:0] dieSel;
  logic spiModeActive;
  logic [15:0] rdWord;
  logic [5:0] rdAddr;
  logic pwmOut, pwmOe, manchesterMode, txBusy;
  logic abortErrorFlag, overrunFlag, checksumFailFlag;
  logic rdStrobe, wrStrobe;
  msm_pkg::msm_wr_t wrCmd;
  msm_pkg::msm_wr_t wrLast;
  int rdCount = 0;
  int wrCount = 0;
  wire logic supplyLevel;
  wire logic pinLevel;
  int errors = 0;
  int samples_checked = 0;

  always #2.5 clk = ~clk;
  // open drain with pull-up: only a pulled-low pin reads low
  assign pinLevel = pwmOe ? pwmOut : 1'h1;

  function automatic logic [7:0] mbyte(input logic [5:0] a);
    return {2'h2, a};
  endfunction
  assign rdWord = {mbyte({rdAddr[5:1], 1'h0}), mbyte({rdAddr[5:1], 1'h1})};

  // strobes stand one cycle; catch them where they have settled
  always @(negedge clk) begin
    if (rdStrobe === 1'h1) rdCount++;
    if (wrStrobe === 1'h1) begin
      wrCount++;
      wrLast = wrCmd;
    end
  end

  msm_link #(.CNTW(16)) msm_link_inst (.clk(clk), .rst_n(rst_n),
    .supplyLevel(supplyLevel), .dieSel(dieSel), .spiModeActive(spiModeActive),
    .rdWord(rdWord), .pwmIn(pinLevel), .pwmOut(pwmOut), .pwmOe(pwmOe),
    .manchesterMode(manchesterMode), .txBusy(txBusy),
    .rdStrobe(rdStrobe), .rdAddr(rdAddr), .wrStrobe(wrStrobe),
    .wrCmd(wrCmd),
    .abortErrorFlag(abortErrorFlag), .overrunFlag(overrunFlag),
    .checksumFailFlag(checksumFailFlag));
  msm_ctrl msm_ctrl_inst (.clk(clk), .pinLevel(pinLevel),
    .supplyLevel(supplyLevel));

  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [2:0] crc3(input logic [31:0] d, input int n);
    logic [2:0] c;
    c = 3'h7;
    for (int i = n - 1; i >= 0; i--) c = {c[1], c[2] ^ d[i] ^ c[0], c[2] ^ d[i]};
    return c;
  endfunction

  function automatic logic [26:0] expResp(input logic [5:0] st,
    input logic [15:0] d);
    return {2'h0, st, d, crc3({st, d}, 22)};
  endfunction

  function automatic logic [31:0] readFrame(input logic [3:0] tid,
    input logic [5:0] a, input logic [2:0] flip);
    return {18'h00000, 1'h1, tid, a, crc3({1'h1, tid, a}, 11) ^ flip};
  endfunction

  task automatic doRead(input logic [3:0] tid, input logic [5:0] a,
    input logic [2:0] flip, output logic ok);
    fork
      msm_ctrl_inst.sendFrame(readFrame(tid, a, flip), 16);
      msm_ctrl_inst.getResp(ok);
    join
    check(pwmOut, 1'h0);
  endtask

  task automatic doWrite(input logic [3:0] tid, input logic [5:0] a,
    input logic [15:0] d);
    msm_ctrl_inst.sendFrame({2'h0, 1'h0, tid, a, d,
      crc3({1'h0, tid, a, d}, 27)}, 32);
    repeat (4) @(negedge clk);
  endtask

  task automatic s_locked();
    logic ok;
    doRead(4'h4, 6'h14, 3'h0, ok);
    check(ok, 1'h0);
    doWrite(4'h4, 6'h05, 16'hA55A);
    check(wrCount, 0);
    check(rdCount, 0);
  endtask

  task automatic s_access();
    // target id left nonzero on purpose: mode codes must ignore it
    doWrite(4'h2, 6'h3F, 16'h62D2);
    check(manchesterMode, 1'h1);
    doWrite(4'h4, 6'h05, 16'hA55A);
    check(wrCount, 1);
    check(wrLast, {4'h4, 6'h05, 16'hA55A});
  endtask

  task automatic s_even();
    logic ok;
    for (int h = 12; h <= 20; h += 8) begin
      msm_ctrl_inst.half = h;
      doRead(4'h4, 6'h14, 3'h0, ok);
      check(ok, 1'h1);
      check(msm_ctrl_inst.resp, expResp(6'h20, {mbyte(6'h14), mbyte(6'h15)}));
      check(rdAddr, 6'h14);
    end
    msm_ctrl_inst.half = 12;
  endtask

  task automatic s_bcast();
    logic ok;
    for (int k = 0; k < 2; k++) begin
      spiModeActive = k[0];
      doRead(k[0] ? 4'h4 : 4'h0, 6'h15, 3'h0, ok);
      check(ok, 1'h1);
      check(msm_ctrl_inst.resp, expResp(6'h08, {8'h00, mbyte(6'h15)}));
    end
    spiModeActive = 1'h0;
  endtask

  task automatic s_skip();
    logic ok;
    doRead(4'hB, 6'h14, 3'h0, ok);
    check(ok, 1'h0);
    check(rdCount, 4);
    doWrite(4'hB, 6'h06, 16'h1234);
    check(wrCount, 1);
  endtask

  task automatic s_overrun();
    logic ok;
    int t;
    fork
      doRead(4'h4, 6'h16, 3'h0, ok);
      begin
        for (t = 0; t < 800 && txBusy !== 1'h1; t++) @(negedge clk);
        check(txBusy, 1'h1);
        repeat (24) @(negedge clk);
        msm_ctrl_inst.sendFrame(readFrame(4'h4, 6'h16, 3'h0), 16);
      end
    join
    check(ok, 1'h1);
    check(msm_ctrl_inst.resp, expResp(6'h20, {mbyte(6'h16), mbyte(6'h17)}));
    check(overrunFlag, 1'h1);
  endtask

  task automatic s_sticky();
    logic ok;
    doRead(4'h4, 6'h14, 3'h5, ok);
    check(ok, 1'h0);
    check(checksumFailFlag, 1'h1);
    // a one as second sync bit breaks the frame
    msm_ctrl_inst.sendFrame(32'h00000001, 2);
    repeat (40) @(negedge clk);
    check(abortErrorFlag, 1'h1);
    doRead(4'h4, 6'h14, 3'h0, ok);
    check(msm_ctrl_inst.resp, expResp(6'h27, {mbyte(6'h14), mbyte(6'h15)}));
    check({abortErrorFlag, overrunFlag, checksumFailFlag}, 3'h0);
  endtask

  task automatic s_exit();
    logic ok;
    doWrite(4'h1, 6'h3F, 16'h0000);
    check(manchesterMode, 1'h0);
    doRead(4'h4, 6'h14, 3'h0, ok);
    check(ok, 1'h0);
  endtask

  initial begin
    rst_n = 1'h0;
    dieSel = 2'h2;
    spiModeActive = 1'h0;
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    repeat (4) @(negedge clk);
    s_locked();
    s_access();
    s_even();
    s_bcast();
    s_skip();
    s_overrun();
    s_sticky();
    s_exit();
    end_of_test();
  end

  // hang guard: counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    end_of_test();
  end
endmodule // manchester_sensor_messaging_bench
`default_nettype wire
